// *** ptoc_top.sv ***
// periodic time output and external time stamp capture
`timescale 1ns/10ps
`default_nettype none
module ptoc_top
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_rd_in,
  output var  logic [31:0] reg_rdata_out,
  input  wire logic        capture_input_pin_in,
  output var  logic        periodic_time_output_out
);
  // =====================================================
  // registers
  logic [31:0]          output_high_period;
  logic [31:0]          output_low_period;
  logic [7:0]           quantization_correction;
  logic [31:0]          output_start_time;
  logic                 output_idle_level;
  logic [31:0]          capture_stamp_low;
  logic [31:0]          capture_stamp_high;
  logic [31:0]          capture_freerun_count;
  logic [31:0]          ns_count;
  logic [31:0]          sec_count;
  logic [31:0]          freerun;
  logic [31:0]          phase;
  logic [2:0]           capt_sync;
  ptoc_pkg::ptoc_state_t state;
  ptoc_pkg::ptoc_state_t next_state;
  logic                 next_out;
  logic [31:0]          next_rdata;

  // =====================================================
  // write decode
  wire wr_cfg   = reg_wr_in && reg_addr_in == ptoc_pkg::OFF_CONFIG;
  wire wr_hi    = reg_wr_in && reg_addr_in == ptoc_pkg::OFF_HIGH_PERIOD;
  wire wr_lo    = reg_wr_in && reg_addr_in == ptoc_pkg::OFF_LOW_PERIOD;
  wire wr_corr  = reg_wr_in && reg_addr_in == ptoc_pkg::OFF_CORRECTION;
  wire wr_start = reg_wr_in && reg_addr_in == ptoc_pkg::OFF_START_TIME;
  // stop is a strobe only, never stored
  wire stop_pulse = wr_cfg && reg_wdata_in[ptoc_pkg::BIT_STOP];
  wire running    = state != ptoc_pkg::ST_IDLE;
  // idle level frozen once the output has been started
  wire idle_wr = wr_cfg && !running;

  // =====================================================
  // time stamp counters
  wire [31:0] ns_plus   = ns_count + ptoc_pkg::NS_STEP;
  wire        ns_wrap   = ns_plus >= ptoc_pkg::NS_PER_SECOND;
  wire [31:0] ns_next   = ns_wrap ? ns_plus - ptoc_pkg::NS_PER_SECOND
                                  : ns_plus;
  wire [63:0] stamp_now = {sec_count, ns_count};

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ns_count  <= ptoc_pkg::RESET_WORD;
      sec_count <= ptoc_pkg::RESET_WORD;
      freerun   <= ptoc_pkg::RESET_WORD;
    end
    else
    begin
      ns_count  <= ns_next;
      sec_count <= sec_count + {31'h00000000, ns_wrap};
      freerun   <= freerun + ptoc_pkg::NS_STEP;
    end
  end

  // =====================================================
  // capture pin: two-stage sync, third stage for the edge
  wire capt_edge = capt_sync[1] && !capt_sync[2];

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      capt_sync             <= 3'h0;
      capture_stamp_low     <= ptoc_pkg::RESET_WORD;
      capture_stamp_high    <= ptoc_pkg::RESET_WORD;
      capture_freerun_count <= ptoc_pkg::RESET_WORD;
    end
    else
    begin
      capt_sync <= {capt_sync[1:0], capture_input_pin_in};
      if (capt_edge)
      begin
        capture_stamp_low     <= stamp_now[31:0];
        capture_stamp_high    <= stamp_now[63:32];
        capture_freerun_count <= freerun;
      end
    end
  end

  // =====================================================
  // timer output sequencer
  // correction stretches every low half by the same amount, so
  // each low half is low period plus correction, rounded up to 16
  wire [31:0] phase_next = phase + ptoc_pkg::NS_STEP;
  wire [31:0] low_limit  = output_low_period
                           + {24'h000000, quantization_correction};
  wire        hi_done    = phase_next >= output_high_period;
  wire        lo_done    = phase_next >= low_limit;
  wire        start_due  = ns_count >= output_start_time;

  always_comb
  begin
    next_state = state;
    case (state)
      ptoc_pkg::ST_IDLE:  next_state = state;
      ptoc_pkg::ST_ARMED:
        if (start_due)
          next_state = ptoc_pkg::ST_HIGH;
      ptoc_pkg::ST_HIGH:
        if (hi_done)
          next_state = ptoc_pkg::ST_LOW;
      ptoc_pkg::ST_LOW:
        if (lo_done)
          next_state = ptoc_pkg::ST_HIGH;
      default: next_state = ptoc_pkg::ST_IDLE;
    endcase
    if (wr_start)
      next_state = ptoc_pkg::ST_ARMED;
    if (stop_pulse && running)
      next_state = ptoc_pkg::ST_IDLE;
  end

  wire next_idle = idle_wr ? reg_wdata_in[ptoc_pkg::BIT_IDLE_LEVEL]
                           : output_idle_level;
  always_comb
  begin
    case (next_state)
      ptoc_pkg::ST_HIGH: next_out = 1'b1;
      ptoc_pkg::ST_LOW:  next_out = 1'b0;
      default:           next_out = next_idle;
    endcase
  end

  wire phase_clear = next_state != state || wr_start;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state                    <= ptoc_pkg::ST_IDLE;
      phase                    <= ptoc_pkg::RESET_WORD;
      output_idle_level        <= 1'b0;
      periodic_time_output_out <= 1'b0;
    end
    else
    begin
      state                    <= next_state;
      phase                    <= phase_clear ? ptoc_pkg::RESET_WORD
                                              : phase_next;
      output_idle_level        <= next_idle;
      periodic_time_output_out <= next_out;
    end
  end

  // =====================================================
  // host registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      output_high_period      <= ptoc_pkg::RESET_WORD;
      output_low_period       <= ptoc_pkg::RESET_WORD;
      quantization_correction <= 8'h00;
      output_start_time       <= ptoc_pkg::RESET_WORD;
    end
    else
    begin
      if (wr_hi)
        output_high_period <= reg_wdata_in;
      if (wr_lo)
        output_low_period <= reg_wdata_in;
      if (wr_corr)
        quantization_correction <= reg_wdata_in[ptoc_pkg::CORR_MSB:0];
      if (wr_start)
        output_start_time <= reg_wdata_in;
    end
  end

  // stop bit always reads zero; idle level reads on bit 2, all other bits zero
  wire [31:0] cfg_view = {29'h00000000, output_idle_level, 2'h0};

  always_comb
  begin
    case (reg_addr_in)
      ptoc_pkg::OFF_CONFIG:      next_rdata = cfg_view;
      ptoc_pkg::OFF_HIGH_PERIOD: next_rdata = output_high_period;
      ptoc_pkg::OFF_LOW_PERIOD:  next_rdata = output_low_period;
      ptoc_pkg::OFF_CORRECTION:
        next_rdata = {24'h000000, quantization_correction};
      ptoc_pkg::OFF_START_TIME:  next_rdata = output_start_time;
      ptoc_pkg::OFF_CAPT_LOW:    next_rdata = capture_stamp_low;
      ptoc_pkg::OFF_CAPT_HIGH:   next_rdata = capture_stamp_high;
      ptoc_pkg::OFF_CAPT_FREE:   next_rdata = capture_freerun_count;
      default:                   next_rdata = ptoc_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      reg_rdata_out <= ptoc_pkg::RESET_WORD;
    else if (reg_rd_in)
      reg_rdata_out <= next_rdata;
  end

  // =====================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  ns_step_a: assert property (
    !ns_wrap |=> ns_count == $past(ns_count) + ptoc_pkg::NS_STEP)
    else $error("time counter did not advance by 16");
  corr_reserved_a: assert property (
    reg_rd_in && reg_addr_in == ptoc_pkg::OFF_CORRECTION
    |=> reg_rdata_out[31:8] == 24'h000000)
    else $error("correction reserved bits not zero");
  start_arm_a: assert property (
    wr_start && !stop_pulse |=> state == ptoc_pkg::ST_ARMED)
    else $error("start write did not arm the output");
  stop_idle_a: assert property (
    stop_pulse && running |=> state == ptoc_pkg::ST_IDLE
    && periodic_time_output_out == output_idle_level)
    else $error("stop did not restore idle level");
  stop_reads_a: assert property (
    reg_rd_in && reg_addr_in == ptoc_pkg::OFF_CONFIG
    |=> !reg_rdata_out[ptoc_pkg::BIT_STOP])
    else $error("stop bit read back as one");
  idle_high_a: assert property (
    wr_cfg && !running && !wr_start
    && reg_wdata_in[ptoc_pkg::BIT_IDLE_LEVEL]
    |=> periodic_time_output_out)
    else $error("idle level write did not raise output");
  idle_lock_a: assert property (
    running |=> output_idle_level == $past(output_idle_level))
    else $error("idle level changed while running");
  capt_low_a: assert property (
    capt_edge |=> capture_stamp_low == $past(ns_count))
    else $error("low stamp capture wrong");
  capt_high_a: assert property (
    capt_edge |=> capture_stamp_high == $past(sec_count))
    else $error("high stamp capture wrong");
  capt_free_a: assert property (
    capt_edge |=> capture_freerun_count == $past(freerun))
    else $error("free-running capture wrong");
  high_to_low_a: assert property (
    state == ptoc_pkg::ST_HIGH && hi_done && !wr_cfg && !wr_start
    |=> state == ptoc_pkg::ST_LOW && !periodic_time_output_out)
    else $error("high period did not end in low");
  capt_once_a: assert property (
    capt_edge |=> !capt_edge)
    else $error("capture edge lasted two cycles");

  started_c: cover property (state == ptoc_pkg::ST_ARMED
    ##[1:100] state == ptoc_pkg::ST_HIGH);
  toggled_c: cover property (state == ptoc_pkg::ST_LOW
    ##[1:100] state == ptoc_pkg::ST_HIGH);
  stopped_c: cover property (stop_pulse && running);
  captured_c: cover property (capt_edge);
endmodule : ptoc_top
`default_nettype wire

// *** ptoc_pkg.sv ***
// constants and types of the timer output and capture block
`default_nettype none
package ptoc_pkg;
  // =====================================================
  // register offsets
  localparam logic [7:0]  OFF_CONFIG      = 8'h84;
  localparam logic [7:0]  OFF_HIGH_PERIOD = 8'h85;
  localparam logic [7:0]  OFF_LOW_PERIOD  = 8'h86;
  localparam logic [7:0]  OFF_CORRECTION  = 8'h87;
  localparam logic [7:0]  OFF_START_TIME  = 8'h88;
  localparam logic [7:0]  OFF_CAPT_LOW    = 8'h89;
  localparam logic [7:0]  OFF_CAPT_HIGH   = 8'h8A;
  localparam logic [7:0]  OFF_CAPT_FREE   = 8'h8B;
  // =====================================================
  // field positions
  localparam int          BIT_STOP        = 3;
  localparam int          BIT_IDLE_LEVEL  = 2;
  localparam int          CORR_MSB        = 7;
  // =====================================================
  // reset values and timing
  localparam logic [31:0] RESET_WORD      = 32'h00000000;
  localparam logic [31:0] NS_STEP         = 32'h00000010;
  localparam logic [31:0] NS_PER_SECOND   = 32'h3B9ACA00;
  localparam int          STAMP_CLOCK_MHZ = 120;
  // =====================================================
  // timer output states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_HIGH,
    ST_LOW
  } ptoc_state_t;
endpackage : ptoc_pkg
`default_nettype wire

// *** ptoc_pin_partner.sv ***
// far-side model: external logic that pulses the capture pin
`timescale 1ns/10ps
`default_nettype none
module ptoc_pin_partner
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       fire_in,
  input  wire logic [7:0] hold_in,
  output var  logic       capture_pin_out
);
  // =====================================================
  // pulse length counter
  logic [7:0] left;

  // a new pulse only after the old one ends, so low gaps stay real
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      left <= 8'h00;
    else if (fire_in && left == 8'h00)
      left <= hold_in;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end

  assign capture_pin_out = (left != 8'h00);
endmodule : ptoc_pin_partner
`default_nettype wire

// *** ptp_timer_output_and_capture_tb.sv ***
// self-checking bench for the timer output and capture block
`timescale 1ns/10ps
`default_nettype none
module ptp_timer_output_and_capture_tb;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic        pin;
  logic        tout;
  logic        fire = 1'b0;
  logic [7:0]  hold = 8'h03;
  int          num_errors = 0;
  int          tests_run = 0;
  int          seed = 46620;
  int          cyc = 0;
  logic [31:0] got, a1, f1;
  int          t1, t2, hi, lo, corr, h, l, k;

  ptoc_top u_ptoc_top (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .capture_input_pin_in(pin),
    .periodic_time_output_out(tout));
  ptoc_pin_partner u_ptoc_pin_partner (.clk_in(clk_in),
    .reset_in(reset_in), .fire_in(fire), .hold_in(hold),
    .capture_pin_out(pin));

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // =====================================================
  // helpers
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobe for one edge, then one idle cycle so strobes never merge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in);
    #1 wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr = a;
    rd = 1'b1;
    @(posedge clk_in);
    #1 d = rdata;
    rd = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : rreg

  task automatic wait_out(input logic lvl, output int n);
    n = 0;
    while (tout !== lvl)
    begin
      @(posedge clk_in);
      #1 n++;
      if (n > 2000)
      begin
        num_errors++;
        report_and_stop();
      end
    end
  endtask : wait_out

  task automatic fire_pin(input logic [7:0] len, output int t);
    hold = len;
    fire = 1'b1;
    t = cyc;
    @(posedge clk_in);
    #1 fire = 1'b0;
  endtask : fire_pin

  // =====================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1 reset_in = 1'b0;
    for (k = 0; k < 8; k++)
    begin
      rreg(8'h84 + k[7:0], got);
      check("reset value", 32'h00000000, got);
    end
    rreg(8'h90, got);
    check("unmapped", 32'h00000000, got);
    wreg(8'h87, 32'hFFFFFFFF);
    rreg(8'h87, got);
    check("correction", 32'h000000FF, got);
    wreg(8'h89, 32'h12345678);
    rreg(8'h89, got);
    check("capture ro", 32'h00000000, got);
    wreg(8'h84, 32'h00000004);
    check("idle high", 32'h1, {31'h0, tout});
    for (k = 0; k < 2; k++)
    begin
      hi = 16 * (1 + ($unsigned($random(seed)) % 8));
      lo = 16 * (1 + ($unsigned($random(seed)) % 8));
      corr = $unsigned($random(seed)) % 16;
      wreg(8'h85, hi);
      wreg(8'h86, lo);
      wreg(8'h87, corr);
      check("before start", 32'(1 - k), {31'h0, tout});
      wreg(8'h88, 32'h00000010);
      if (k == 0)
        wreg(8'h84, 32'h00000000);
      wait_out(1'b0, h);
      wait_out(1'b1, l);
      wait_out(1'b0, h);
      wait_out(1'b1, l);
      check("high cycles", hi / 16, h);
      check("low cycles", (lo + corr + 15) / 16, l);
      wreg(8'h84, 32'h00000008);
      check("stopped", 32'(1 - k), {31'h0, tout});
      rreg(8'h84, got);
      check("config", 32'(4 - 4 * k), got);
      wreg(8'h84, 32'h00000000);
    end
    // stamp after edge m is 16*(m-8); capture lands 3 edges after fire
    fire_pin(8'h14, t1);
    repeat (30) @(posedge clk_in);
    #1 rreg(8'h89, a1);
    rreg(8'h8B, f1);
    rreg(8'h8A, got);
    check("stamp high", 32'h00000000, got);
    check("stamp model", 32'(16 * (t1 - 5)), a1);
    check("free count", 32'(16 * (t1 - 5)), f1);
    fire_pin(8'h03, t2);
    repeat (10) @(posedge clk_in);
    #1 rreg(8'h89, got);
    check("stamp low", a1 + 16 * (t2 - t1), got);
    rreg(8'h8B, got);
    check("free step", f1 + 16 * (t2 - t1), got);
    report_and_stop();
  end
endmodule : ptp_timer_output_and_capture_tb
`default_nettype wire
